//--- inc/port_wake_and_interrupt_ctrl_defines.vh
// register map, field positions and reset values of the port wake and interrupt block
// assumes a 32-bit AXI4-Lite register port, one aligned word per register
`ifndef PORT_WAKE_AND_INTERRUPT_CTRL_DEFINES_VH
`define PORT_WAKE_AND_INTERRUPT_CTRL_DEFINES_VH

// printed register indices; byte address is four times the index
`define IDX_EVENT_FLAGS     8'h13
`define IDX_WAKE_ENABLE     8'h17
`define IDX_IRQ_STATUS      8'h1B
`define IDX_IRQ_MASK        8'h1F
// block-level registers
`define IDX_BLK_STATUS      8'h20
`define IDX_BLK_MASK        8'h21
`define IDX_MAC_LO          8'h22
`define IDX_MAC_HI          8'h23

// field positions shared by the four port registers
`define BIT_MAGIC           2
`define BIT_LINK            1
`define BIT_ENERGY          0
`define BIT_PTP             2
`define BIT_PHY             1
`define BIT_ACL             0

// block status bits
`define BLK_WAKE_RISE       0
`define BLK_PORT_IRQ_RISE   1
`define BLK_ACL_EVENT       2

// reset values
`define RST_FIELD3          3'h0
`define RST_MAC             48'h0000_0000_0000

// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

//--- hdl/port_wake_and_interrupt_ctrl.v
// per-port wake and interrupt gating with its AXI4-Lite register file
// assumes detection pulses and pending levels come from logic on aclk
`timescale 1ns/1ps
`default_nettype none
`include "port_wake_and_interrupt_ctrl_defines.vh"

// overview of the block
//
// one switch port, replicated per port by the parent
// the parent ties IS_PHY_PORT low on external MAC ports
//
// wake path
//   detection pulses latch into three sticky event flags
//   magic packets count only when their destination
//   equals the switch address held in the MAC registers
//   each flag reaches the wake pin through its enable bit
//   link-up and energy have no meaning without a PHY,
//   so on MAC ports those flags never set and their
//   enables are ignored; magic packets work on every port
//   software clears a flag by writing a one to it
//   the wake pin is a level: it stays high until the
//   flag or its enable is cleared
//
// interrupt path
//   PTP and PHY summaries are levels that follow their
//   sources; the individual causes live elsewhere
//   the ACL summary is sticky and only a change of the
//   ACL mask bit clears it, since the status is read-only
//   mask bits are active low, so reset enables all three on PHY ports and only ACL on MAC ports
//   the PTP source must pass its per-cause enables as well
//   as the port mask bit before it reaches the request
//   enabled pending bits are ORed into port_irq_req
//
// block-level extras
//   a sticky status register records wake and request
//   rises plus raw ACL pulses; its mask is active high
//   and gates the single irq output
//
// timing
//   a register write lands one edge after the later of
//   the address and data handshakes
//   a read answers on the same edge as its address handshake
//   outputs are flopped, so they trail their cause by an
//   edge; software polling the pin must allow for that
//
// hazards
//   a clear and a set in the same cycle: the set wins,
//   so an event arriving during a clear is never lost
//   all detection inputs must already be on aclk; there
//   are no synchronisers here, by intent, to save latency

module port_wake_and_interrupt_ctrl #(
    parameter IS_PHY_PORT = 1,
    parameter PTP_CAUSES  = 8
) (
    // clock and reset
    input  wire                  aclk,
    input  wire                  aresetn,
    // write address channel
    input  wire [31:0]           s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output reg                   s_axi_awready,
    // write data channel
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output reg                   s_axi_wready,
    // write response channel
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    // read address channel
    input  wire [31:0]           s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output reg                   s_axi_arready,
    // read data channel
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    // detection pulses from the port receive logic
    input  wire                  magic_pkt_seen,
    input  wire [47:0]           magic_pkt_dest,
    input  wire                  link_up_seen,
    input  wire                  energy_seen,
    // interrupt sources from the PTP, PHY and ACL logic
    input  wire [PTP_CAUSES-1:0] ptp_cause,
    input  wire [PTP_CAUSES-1:0] ptp_cause_en,
    input  wire                  phy_irq_pending,
    input  wire                  acl_count_irq,
    // outputs to the host side and to global status
    output reg                   wake_event_pin,
    output reg                   port_irq_req,
    output reg                   irq
);

    // byte-address match against a register index
    function hit;
        input [31:0] addr;
        input [7:0]  idx;
        begin
            hit = (addr[31:2] == {22'h000000, idx});
        end
    endfunction

    // phy-only fields collapse to constants on MAC ports
    localparam [2:0] PHY_FIELDS = (IS_PHY_PORT != 0) ? 3'h7 : 3'h1;
    // wake fields differ: magic stays, link and energy go on MAC ports
    localparam [2:0] WAKE_FIELDS = (IS_PHY_PORT != 0) ? 3'h7 : 3'h4;

    // register state
    reg  [2:0]  event_flags_r;
    reg  [2:0]  wake_enable_r;
    reg  [2:0]  irq_mask_r;
    reg         acl_status_r;
    reg  [2:0]  blk_status_r;
    reg  [2:0]  blk_mask_r;
    reg  [47:0] mac_addr_r;
    reg         wake_prev_r;
    reg         preq_prev_r;

    // write channel bookkeeping
    reg         aw_got_r;
    reg         w_got_r;
    reg  [31:0] awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;

    // next values
    reg  [2:0]  event_flags_nxt;
    reg  [2:0]  wake_enable_nxt;
    reg  [2:0]  irq_mask_nxt;
    reg         acl_status_nxt;
    reg  [2:0]  blk_status_nxt;
    reg  [2:0]  blk_mask_nxt;
    reg  [47:0] mac_addr_nxt;
    reg  [31:0] rdata_nxt;
    reg  [1:0]  rresp_nxt;
    reg  [1:0]  bresp_nxt;

    wire        do_write;
    wire        lane0;
    wire        magic_ok;
    wire [2:0]  event_set;
    wire [2:0]  wake_en_eff;
    wire [2:0]  irq_status;
    wire [2:0]  mask_eff;
    wire [2:0]  irq_fwd;
    wire        wake_now;
    wire        preq_now;
    wire [2:0]  blk_set;

    assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
    assign lane0    = wstrb_r[0];

    // destination must equal the switch address to count
    assign magic_ok  = magic_pkt_seen & (magic_pkt_dest == mac_addr_r);
    assign event_set = {magic_ok, link_up_seen, energy_seen} & WAKE_FIELDS;

    // link and energy enables are dead on MAC ports
    // both the flag and its enable are cut, so a stale
    // enable write on a MAC port can never raise the pin
    assign wake_en_eff = wake_enable_r & WAKE_FIELDS;
    assign wake_now    = |(event_flags_r & wake_en_eff);

    // summary bits follow their sources as levels; ACL is sticky
    assign irq_status[`BIT_PTP] = (|ptp_cause) & PHY_FIELDS[`BIT_PTP];
    assign irq_status[`BIT_PHY] = phy_irq_pending & PHY_FIELDS[`BIT_PHY];
    assign irq_status[`BIT_ACL] = acl_status_r;

    // mask one disables; absent fields stay disabled on MAC ports
    assign mask_eff = irq_mask_r | ~PHY_FIELDS;
    // the PTP source needs its per-cause enable too
    assign irq_fwd[`BIT_PTP] = (|(ptp_cause & ptp_cause_en)) & irq_status[`BIT_PTP]
                               & ~mask_eff[`BIT_PTP];
    assign irq_fwd[`BIT_PHY] = irq_status[`BIT_PHY] & ~mask_eff[`BIT_PHY];
    assign irq_fwd[`BIT_ACL] = irq_status[`BIT_ACL] & ~mask_eff[`BIT_ACL];
    assign preq_now = |irq_fwd;

    // block events for the sticky status register
    assign blk_set[`BLK_WAKE_RISE]     = wake_now & ~wake_prev_r;
    assign blk_set[`BLK_PORT_IRQ_RISE] = preq_now & ~preq_prev_r;
    assign blk_set[`BLK_ACL_EVENT]     = acl_count_irq;

    // register writes; hardware set always wins over a clear in the same cycle
    // every next value starts from hold plus hardware set,
    // then the decoded write overrides the field it owns;
    // writes to reserved bits are simply not stored
    always @* begin
        event_flags_nxt = event_flags_r | event_set;
        wake_enable_nxt = wake_enable_r;
        irq_mask_nxt    = irq_mask_r;
        acl_status_nxt  = acl_status_r | acl_count_irq;
        blk_status_nxt  = blk_status_r | blk_set;
        blk_mask_nxt    = blk_mask_r;
        mac_addr_nxt    = mac_addr_r;
        bresp_nxt       = `RESP_OKAY;
        if (do_write) begin
            if (hit(awaddr_r, `IDX_EVENT_FLAGS)) begin
                if (lane0)
                    event_flags_nxt = (event_flags_r & ~wdata_r[2:0]) | event_set;
            end else if (hit(awaddr_r, `IDX_WAKE_ENABLE)) begin
                if (lane0)
                    wake_enable_nxt = wdata_r[2:0];
            end else if (hit(awaddr_r, `IDX_IRQ_STATUS)) begin
                bresp_nxt = `RESP_OKAY;                                                 // read-only, write dropped
            end else if (hit(awaddr_r, `IDX_IRQ_MASK)) begin
                if (lane0) begin
                    irq_mask_nxt = wdata_r[2:0];
                    // a change of the ACL mask bit clears the ACL status
                    if (wdata_r[`BIT_ACL] != irq_mask_r[`BIT_ACL])
                        acl_status_nxt = acl_count_irq;
                end
            end else if (hit(awaddr_r, `IDX_BLK_STATUS)) begin
                if (lane0)
                    blk_status_nxt = (blk_status_r & ~wdata_r[2:0]) | blk_set;
            end else if (hit(awaddr_r, `IDX_BLK_MASK)) begin
                if (lane0)
                    blk_mask_nxt = wdata_r[2:0];
            end else if (hit(awaddr_r, `IDX_MAC_LO)) begin
                if (wstrb_r[0]) mac_addr_nxt[7:0]   = wdata_r[7:0];
                if (wstrb_r[1]) mac_addr_nxt[15:8]  = wdata_r[15:8];
                if (wstrb_r[2]) mac_addr_nxt[23:16] = wdata_r[23:16];
                if (wstrb_r[3]) mac_addr_nxt[31:24] = wdata_r[31:24];
            end else if (hit(awaddr_r, `IDX_MAC_HI)) begin
                if (wstrb_r[0]) mac_addr_nxt[39:32] = wdata_r[7:0];
                if (wstrb_r[1]) mac_addr_nxt[47:40] = wdata_r[15:8];
            end else begin
                bresp_nxt = `RESP_SLVERR;
            end
        end
    end

    // read mux, reserved bits read as zero
    // decoded straight from the bus address, so the data
    // is captured on the same edge as the handshake
    always @* begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = `RESP_OKAY;
        if (hit(s_axi_araddr, `IDX_EVENT_FLAGS))
            rdata_nxt = {29'h0000_0000, event_flags_r};
        else if (hit(s_axi_araddr, `IDX_WAKE_ENABLE))
            rdata_nxt = {29'h0000_0000, wake_enable_r};
        else if (hit(s_axi_araddr, `IDX_IRQ_STATUS))
            rdata_nxt = {29'h0000_0000, irq_status};
        else if (hit(s_axi_araddr, `IDX_IRQ_MASK))
            rdata_nxt = {29'h0000_0000, irq_mask_r};
        else if (hit(s_axi_araddr, `IDX_BLK_STATUS))
            rdata_nxt = {29'h0000_0000, blk_status_r};
        else if (hit(s_axi_araddr, `IDX_BLK_MASK))
            rdata_nxt = {29'h0000_0000, blk_mask_r};
        else if (hit(s_axi_araddr, `IDX_MAC_LO))
            rdata_nxt = mac_addr_r[31:0];
        else if (hit(s_axi_araddr, `IDX_MAC_HI))
            rdata_nxt = {16'h0000, mac_addr_r[47:32]};
        else
            rresp_nxt = `RESP_SLVERR;
    end

    // write channels: address and data taken in either order, one write in flight
    // each ready drops on its own handshake and both come
    // back together when the response is taken; this costs
    // throughput but keeps a single write buffer
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 32'h0000_0000;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r      <= s_axi_awaddr;
                aw_got_r      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                w_got_r      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= bresp_nxt;
            end
            // ready returns only after the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel: data registered on the address handshake
    // arready stays low while data waits, one read at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdata_nxt;
            s_axi_rresp   <= rresp_nxt;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // register state and flopped outputs; outputs lag the state by one edge
    // the previous-value flops feed the rise detectors of
    // the block status; they reset low like the outputs,
    // so no false rise follows reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            event_flags_r  <= `RST_FIELD3;
            wake_enable_r  <= `RST_FIELD3;
            irq_mask_r     <= `RST_FIELD3;
            acl_status_r   <= 1'b0;
            blk_status_r   <= `RST_FIELD3;
            blk_mask_r     <= `RST_FIELD3;
            mac_addr_r     <= `RST_MAC;
            wake_prev_r    <= 1'b0;
            preq_prev_r    <= 1'b0;
            wake_event_pin <= 1'b0;
            port_irq_req   <= 1'b0;
            irq            <= 1'b0;
        end else begin
            event_flags_r  <= event_flags_nxt;
            wake_enable_r  <= wake_enable_nxt;
            irq_mask_r     <= irq_mask_nxt;
            acl_status_r   <= acl_status_nxt;
            blk_status_r   <= blk_status_nxt;
            blk_mask_r     <= blk_mask_nxt;
            mac_addr_r     <= mac_addr_nxt;
            wake_prev_r    <= wake_now;
            preq_prev_r    <= preq_now;
            wake_event_pin <= wake_now;
            port_irq_req   <= preq_now;
            // block mask is active high: one lets the bit through
            irq            <= |(blk_status_r & blk_mask_r);
        end
    end

endmodule
`default_nettype wire

//--- bench/wake_irq_monitor.sv
// checker for the port wake and interrupt block, bound onto its top module
// assumes every port is sampled on aclk and aresetn is a synchronous low reset
`timescale 1ns/1ps
`default_nettype none
module wake_irq_monitor (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // events and wake output
    input wire logic        magic_pkt_seen,
    input wire logic        link_up_seen,
    input wire logic        energy_seen,
    input wire logic        wake_event_pin
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // write answered two edges after address and data are taken together
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    // a pending answer blocks the next request
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read data not released");
    err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    // a wake rise needs a detection two edges back or a register write just done
    wake_cause_a: assert property ($rose(wake_event_pin) |->
        $past(magic_pkt_seen || link_up_seen || energy_seen, 2) || $past(s_axi_bvalid))
        else $error("wake rose without cause");
endmodule
`default_nettype wire

//--- bench/host_model.sv
// host processor model: watches the wake pin and counts wake-ups
// assumes the pin is a registered level on aclk; software reactions come from the bench
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // pin from the device
    input  wire logic       wake_event_pin,
    // wake-ups seen
    output var  logic [7:0] wake_count
);
    logic wake_d_r;
    // counts rises only, since the pin stays high until software clears the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_d_r <= 1'b0;
            wake_count <= 8'h00;
        end else begin
            wake_d_r <= wake_event_pin;
            if (wake_event_pin && !wake_d_r)
                wake_count <= wake_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench: registers over AXI4-Lite, events and sources driven directly
// assumes the design header is on the include path and a PHY port build
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        aclk = 0, aresetn = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [47:0] magic_pkt_dest = 48'h1122_3344_5566;
    logic        magic_pkt_seen = 0, link_up_seen = 0, energy_seen = 0, acl_count_irq = 0, phy_irq_pending = 0;
    logic [7:0]  ptp_cause = 0, ptp_cause_en = 0, wake_count;
    logic        wake_event_pin, port_irq_req, irq;
    logic        mac_wake, mac_preq;
    integer      num_errors = 0, compares = 0;

    always #5 aclk = ~aclk;
    port_wake_and_interrupt_ctrl DUT (.*);
    // MAC-port build shares the bus; only its pins are watched
    port_wake_and_interrupt_ctrl #(.IS_PHY_PORT(0)) u_mac (.*, .s_axi_awready(), .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
        .s_axi_rvalid(), .wake_event_pin(mac_wake), .port_irq_req(mac_preq), .irq());
    host_model u_host (.aclk, .aresetn, .wake_event_pin, .wake_count);

    task automatic chk(input [31:0] seen, input [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // a bus answer that never comes ends the run
    task automatic tmo(input integer n);
        if (n >= 20) begin
            num_errors = num_errors + 1;
            give_verdict;
        end
    endtask
    task automatic wr(input [31:0] a, input [31:0] d, input [1:0] r);
        integer n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            n = n + 1;
        end while (s_axi_bvalid !== 1'b1 && n < 20);
        s_axi_bready <= 1'b0;
        tmo(n);
        chk(s_axi_bresp, r);
    endtask
    task automatic rd(input [31:0] a, input [31:0] d, input [1:0] r);
        integer n;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            n = n + 1;
        end while (s_axi_rvalid !== 1'b1 && n < 20);
        s_axi_rready <= 1'b0;
        tmo(n);
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
    endtask
    // one-cycle pulses: acl, magic, link, energy
    task automatic ev(input [3:0] s);
        @(posedge aclk);
        {acl_count_irq, magic_pkt_seen, link_up_seen, energy_seen} <= s;
        @(posedge aclk);
        {acl_count_irq, magic_pkt_seen, link_up_seen, energy_seen} <= 4'h0;
    endtask
    task automatic gap(input integer n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    // level sources: ptp cause, its enable, phy pending
    task automatic src(input p, input e, input h);
        @(posedge aclk);
        ptp_cause <= {7'h00, p};
        ptp_cause_en <= {7'h00, e};
        phy_irq_pending <= h;
        gap(2);
    endtask

    initial begin
        integer i;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 3; i++) rd(32'h5C + 16 * i, 0, 0);
        wr(32'h88, 32'h3344_5566, 0);
        wr(32'h8C, 32'h0000_1122, 0);
        wr(32'h5C, 32'hFFFF_FFF8, 0);
        rd(32'h5C, 0, 0);
        wr(32'h7C, 32'hFFFF_FFF8, 0);
        rd(32'h7C, 0, 0);
        // detections latch but stay off the pin while disabled
        ev(4'h7);
        gap(2);
        chk(wake_event_pin, 0);
        rd(32'h4C, 7, 0);
        wr(32'h4C, 7, 0);
        rd(32'h4C, 0, 0);
        for (i = 0; i < 3; i++) begin
            wr(32'h5C, 1 << i, 0);
            ev(1 << i);
            gap(2);
            chk(wake_event_pin, 1);
            chk(mac_wake, i == 2);
            wr(32'h4C, 1 << i, 0);
            gap(1);
            chk(wake_event_pin, 0);
            chk(mac_wake, 0);
        end
        // wrong destination must not count as a magic packet
        magic_pkt_dest <= 48'h1122_3344_5567;
        ev(4'h4);
        gap(2);
        rd(32'h4C, 0, 0);
        src(0, 0, 1);
        rd(32'h6C, 2, 0);
        chk(port_irq_req, 1);
        chk(mac_preq, 0);
        wr(32'h7C, 2, 0);
        gap(1);
        chk(port_irq_req, 0);
        wr(32'h7C, 0, 0);
        src(1, 0, 0);
        rd(32'h6C, 4, 0);
        chk(port_irq_req, 0);
        src(1, 1, 0);
        chk(port_irq_req, 1);
        chk(mac_preq, 0);
        src(0, 0, 0);
        ev(4'h8);
        gap(2);
        rd(32'h6C, 1, 0);
        chk(port_irq_req, 1);
        chk(mac_preq, 1);
        wr(32'h7C, 0, 0);
        rd(32'h6C, 1, 0);
        wr(32'h7C, 1, 0);
        rd(32'h6C, 0, 0);
        wr(32'h7C, 0, 0);
        // block interrupt: raise, mask, unmask, clear
        wr(32'h80, 7, 0);
        wr(32'h84, 1, 0);
        wr(32'h5C, 2, 0);
        ev(4'h2);
        gap(3);
        chk(irq, 1);
        rd(32'h80, 1, 0);
        wr(32'h84, 0, 0);
        gap(1);
        chk(irq, 0);
        wr(32'h84, 1, 0);
        gap(1);
        chk(irq, 1);
        wr(32'h80, 1, 0);
        gap(1);
        chk(irq, 0);
        wr(32'h00, 5, 2);
        rd(32'h00, 0, 2);
        chk(wake_count, 4);
        give_verdict;
    end
endmodule
bind port_wake_and_interrupt_ctrl wake_irq_monitor u_mon (.*);
`default_nettype wire
